/* tsc_pkg.sv */
// Constants, state codes and field layouts shared by the sensor control
// block and its alarm qualifier.
// Assumes a 40 MHz core clock.
package tsc_pkg;

  // ==========================================================
  // Register pointers
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_TOS = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] HYST_RESET = 16'h4B00;
  localparam logic [15:0] TOS_RESET = 16'h5000;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [2:0] SYNC_RESET = 3'h3;
  localparam logic ALARM_OE_RESET = 1'b1;

  // ==========================================================
  // Configuration field positions
  localparam int CFG_SHUT = 0;
  localparam int CFG_MODE = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_FQ_HI = 4;
  localparam int CFG_FMT = 5;
  localparam int CFG_TOUT = 6;
  localparam int CFG_ONE = 7;

  // ==========================================================
  // Data format and timing
  localparam logic [15:0] EXT_OFFSET = 16'h4000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int CLK_HZ = 40000000;
  localparam int TIMEOUT_MS = 50;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);

  // ==========================================================
  // State codes
  typedef enum logic [6:0]
  {
    BUS_IDLE = 7'h01,
    BUS_ADDR = 7'h02,
    BUS_ACK_A = 7'h04,
    BUS_WRITE = 7'h08,
    BUS_ACK_W = 7'h10,
    BUS_READ = 7'h20,
    BUS_ACK_R = 7'h40
  } tsc_bus_state_type;

  typedef enum logic [2:0]
  {
    SEQ_RUN = 3'h1,
    SEQ_SHUT = 3'h2,
    SEQ_ONE = 3'h4
  } tsc_seq_state_type;

  // ==========================================================
  // Fault queue decode
  function automatic logic [2:0] tsc_fault_limit(input logic [1:0] code);
    case (code)
      2'h0: tsc_fault_limit = 3'h1;
      2'h1: tsc_fault_limit = 3'h2;
      2'h2: tsc_fault_limit = 3'h4;
      default: tsc_fault_limit = 3'h6;
    endcase
  endfunction

endpackage

/* tsc_alarm_if.sv */
// Signals between the sensor control top and its alarm qualifier.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface tsc_alarm_if;
  logic ce;
  logic sample_ev;
  logic [15:0] temp;
  logic [15:0] tos;
  logic [15:0] hyst;
  logic int_mode;
  logic [1:0] fault_code;
  logic read_ev;
  logic shut_ev;
  logic active;

  modport top
  (
    output ce, sample_ev, temp, tos, hyst, int_mode, fault_code,
    output read_ev, shut_ev,
    input active
  );

  modport alarm
  (
    input ce, sample_ev, temp, tos, hyst, int_mode, fault_code,
    input read_ev, shut_ev,
    output active
  );
endinterface

/* tsc_alarm.sv */
// Fault queue and alarm state for the over-temperature output.
// Assumes sample_ev pulses once per finished conversion with temp valid.
`timescale 1ns/1ps
module tsc_alarm
(
  input wire logic clk_i,
  input wire logic rst_i,
  tsc_alarm_if.alarm al
);

  logic [2:0] fault_cnt;
  logic seek_low;
  logic active;
  logic seek_high;
  logic fault;
  logic hit;

  // ==========================================================
  // Fault test
  // In interrupt mode the direction flips after each trip; in comparator
  // mode the present alarm level picks the threshold.
  assign seek_high = al.int_mode ? !seek_low : !active;
  assign fault = seek_high ? ($signed(al.temp) > $signed(al.tos))
                           : ($signed(al.temp) < $signed(al.hyst));
  assign hit = (fault_cnt + 3'h1) >= tsc_pkg::tsc_fault_limit(al.fault_code);
  assign al.active = active;

  // ==========================================================
  // Consecutive fault counter
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      fault_cnt <= 3'h0;
    else if (al.ce && al.sample_ev)
    begin
      if (!fault || hit)
        fault_cnt <= 3'h0;
      else
        fault_cnt <= fault_cnt + 3'h1;
    end
  end

  // ==========================================================
  // Alarm level
  // A trip in the same cycle as a read wins, so no event is lost.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      active <= 1'b0;
      seek_low <= 1'b0;
    end
    else if (al.ce)
    begin
      if (al.sample_ev && fault && hit)
      begin
        if (al.int_mode)
        begin
          active <= 1'b1;
          seek_low <= !seek_low;
        end
        else
          active <= !active;
      end
      else if (al.int_mode && (al.read_ev || al.shut_ev))
        active <= 1'b0;
    end
  end

endmodule

/* tsc_top.sv */
// Configuration and control logic of a serial temperature sensor: serial
// register access, conversion sequencing, data format and alarm output.
// Assumes a conversion engine on clk_i and an open-drain serial bus whose
// clock line also clocks the bit sampler.
`timescale 1ns/1ps

// Operation
// - Fault queue bits select 1, 2, 4, 6.
// - Trip only after consecutive qualifying conversions.
// - Format bit zero gives plain two's complement.
// - Extended format stores temperature minus 64 degrees.
// - New format applies after next conversion completes.
// - Timeout bit set disables bus lockup timeout.
// - Data line low too long resets interface.
// - One-shot write in shutdown starts conversion.
// - One-shot finishes and returns to shutdown.
// - One-shot bit clears itself when done.
// - One-shot write ignored outside shutdown.
// - Power-on configuration is all zero defaults.
// - Shutdown after current conversion; clearing restarts.
// - Comparator mode follows high and hysteresis thresholds.
// - Interrupt mode holds alarm until read or shutdown.
// - Polarity bit selects alarm active level.
module tsc_top
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int TIMEOUT_CYCLES = tsc_pkg::TIMEOUT_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_temp_i,
  output logic overtemp_alarm_o,
  output logic overtemp_alarm_oe_n_o
);

  localparam logic [21:0] TIMEOUT_LIMIT = TIMEOUT_CYCLES[21:0];

  logic rx_tog;
  logic rx_bit;
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic scl_d;
  logic sda_d;
  logic tog_d;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic rx_ev;
  logic [21:0] low_cnt;
  logic bus_timeout;
  tsc_pkg::tsc_bus_state_type bus_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [1:0] ptr;
  logic byte_lo;
  logic ptr_seen;
  logic rw;
  logic acked;
  logic sda_release;
  logic wr_en;
  logic [1:0] wr_ptr;
  logic wr_lo;
  logic [7:0] wr_data;
  logic rd_ev;
  logic [6:0] cfg;
  logic [15:0] hyst;
  logic [15:0] tos;
  logic [15:0] temp;
  logic sample_ev;
  tsc_pkg::tsc_seq_state_type seq_state;
  logic busy;
  logic shut_ev;
  logic one_req;
  logic [7:0] next_byte;
  logic alarm_level;

  tsc_alarm_if al_if();

  // ==========================================================
  // Register read decode
  function automatic logic [7:0] rd_byte(input logic [1:0] p,
                                         input logic lo);
    case (p)
      tsc_pkg::PTR_TEMP: rd_byte = lo ? temp[7:0] : temp[15:8];
      tsc_pkg::PTR_CFG:
        rd_byte = {seq_state == tsc_pkg::SEQ_ONE, cfg};
      tsc_pkg::PTR_HYST: rd_byte = lo ? hyst[7:0] : hyst[15:8];
      default: rd_byte = lo ? tos[7:0] : tos[15:8];
    endcase
  endfunction

  // The pointer stops at the last register instead of wrapping.
  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == tsc_pkg::PTR_TOS) ? p : p + 2'h1;
  endfunction

  always_comb next_byte = rd_byte(ptr, byte_lo);

  // ==========================================================
  // Link side bit sampler
  // Data is taken on the rising serial clock; the toggle tells the core
  // a bit is ready, and the bit stays still for the rest of the period.
  always_ff @(posedge scl_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_tog <= 1'b0;
      rx_bit <= 1'b0;
    end
    else
    begin
      rx_tog <= !rx_tog;
      rx_bit <= sda_i;
    end
  end

  // ==========================================================
  // Synchronisers
  assign pin_raw = {rx_tog, sda_i, scl_i};

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_sync
      logic s1;
      logic s2;
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          s1 <= tsc_pkg::SYNC_RESET[i];
          s2 <= tsc_pkg::SYNC_RESET[i];
        end
        else if (ce_i)
        begin
          s1 <= pin_raw[i];
          s2 <= s1;
        end
      end
      assign pin_sync[i] = s2;
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      tog_d <= 1'b0;
    end
    else if (ce_i)
    begin
      scl_d <= pin_sync[0];
      sda_d <= pin_sync[1];
      tog_d <= pin_sync[2];
    end
  end

  assign scl_fall = scl_d && !pin_sync[0];
  assign bus_start = pin_sync[0] && sda_d && !pin_sync[1];
  assign bus_stop = pin_sync[0] && !sda_d && pin_sync[1];
  assign rx_ev = pin_sync[2] ^ tog_d;

  // ==========================================================
  // Bus lockup timer
  // The count holds at its limit so the engine stays idle while the line
  // remains low.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      low_cnt <= 22'h000000;
    else if (ce_i)
    begin
      if (cfg[tsc_pkg::CFG_TOUT] || pin_sync[1])
        low_cnt <= 22'h000000;
      else if (low_cnt != TIMEOUT_LIMIT)
        low_cnt <= low_cnt + 22'h000001;
    end
  end

  assign bus_timeout = !cfg[tsc_pkg::CFG_TOUT] && !pin_sync[1]
                       && (low_cnt == TIMEOUT_LIMIT);

  // ==========================================================
  // Serial protocol engine
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_state <= tsc_pkg::BUS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= tsc_pkg::PTR_TEMP;
      byte_lo <= 1'b0;
      ptr_seen <= 1'b0;
      rw <= 1'b0;
      acked <= 1'b0;
      sda_release <= 1'b1;
      wr_en <= 1'b0;
      wr_ptr <= tsc_pkg::PTR_TEMP;
      wr_lo <= 1'b0;
      wr_data <= 8'h00;
      rd_ev <= 1'b0;
    end
    else if (ce_i)
    begin
      wr_en <= 1'b0;
      rd_ev <= 1'b0;
      if (bus_timeout || bus_stop)
      begin
        bus_state <= tsc_pkg::BUS_IDLE;
        sda_release <= 1'b1;
      end
      else if (bus_start)
      begin
        bus_state <= tsc_pkg::BUS_ADDR;
        bit_cnt <= 4'h0;
        ptr_seen <= 1'b0;
        byte_lo <= 1'b0;
        sda_release <= 1'b1;
      end
      else
      begin
        case (bus_state)
          tsc_pkg::BUS_IDLE:
          begin
            sda_release <= 1'b1;
          end
          tsc_pkg::BUS_ADDR, tsc_pkg::BUS_WRITE:
          begin
            if (rx_ev && bit_cnt != tsc_pkg::BYTE_BITS)
            begin
              shreg <= {shreg[6:0], rx_bit};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == tsc_pkg::BYTE_BITS)
            begin
              if (bus_state == tsc_pkg::BUS_ADDR)
              begin
                if (shreg[7:1] == DEV_ADDR)
                begin
                  rw <= shreg[0];
                  sda_release <= 1'b0;
                  bus_state <= tsc_pkg::BUS_ACK_A;
                end
                else
                  bus_state <= tsc_pkg::BUS_IDLE;
              end
              else
              begin
                sda_release <= 1'b0;
                bus_state <= tsc_pkg::BUS_ACK_W;
                if (!ptr_seen)
                begin
                  ptr <= shreg[1:0];
                  ptr_seen <= 1'b1;
                  byte_lo <= 1'b0;
                end
                else
                begin
                  wr_en <= 1'b1;
                  wr_ptr <= ptr;
                  wr_lo <= byte_lo;
                  wr_data <= shreg;
                  byte_lo <= !byte_lo;
                  if (byte_lo)
                    ptr <= ptr_inc(ptr);
                end
              end
            end
          end
          tsc_pkg::BUS_ACK_A, tsc_pkg::BUS_ACK_R:
          begin
            if (rx_ev)
              acked <= !rx_bit;
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if ((bus_state == tsc_pkg::BUS_ACK_A && rw)
                  || (bus_state == tsc_pkg::BUS_ACK_R && acked))
              begin
                txreg <= next_byte;
                sda_release <= next_byte[7];
                rd_ev <= 1'b1;
                byte_lo <= !byte_lo;
                if (byte_lo)
                  ptr <= ptr_inc(ptr);
                bus_state <= tsc_pkg::BUS_READ;
              end
              else if (bus_state == tsc_pkg::BUS_ACK_A)
              begin
                sda_release <= 1'b1;
                bus_state <= tsc_pkg::BUS_WRITE;
              end
              else
              begin
                sda_release <= 1'b1;
                bus_state <= tsc_pkg::BUS_IDLE;
              end
            end
          end
          tsc_pkg::BUS_ACK_W:
          begin
            if (scl_fall)
            begin
              sda_release <= 1'b1;
              bit_cnt <= 4'h0;
              bus_state <= tsc_pkg::BUS_WRITE;
            end
          end
          tsc_pkg::BUS_READ:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == tsc_pkg::LAST_BIT)
              begin
                sda_release <= 1'b1;
                acked <= 1'b0;
                bus_state <= tsc_pkg::BUS_ACK_R;
              end
              else
              begin
                txreg <= {txreg[6:0], 1'b0};
                sda_release <= txreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          default:
          begin
            bus_state <= tsc_pkg::BUS_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = sda_release;

  // ==========================================================
  // Register file
  // A second configuration byte simply overwrites the first.
  assign one_req = wr_en && (wr_ptr == tsc_pkg::PTR_CFG)
                   && wr_data[tsc_pkg::CFG_ONE];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg <= tsc_pkg::CFG_RESET;
    else if (ce_i && wr_en && wr_ptr == tsc_pkg::PTR_CFG)
      cfg <= wr_data[6:0];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hyst <= tsc_pkg::HYST_RESET;
      tos <= tsc_pkg::TOS_RESET;
    end
    else if (ce_i && wr_en)
    begin
      if (wr_ptr == tsc_pkg::PTR_HYST && wr_lo)
        hyst[7:0] <= wr_data;
      else if (wr_ptr == tsc_pkg::PTR_HYST)
        hyst[15:8] <= wr_data;
      else if (wr_ptr == tsc_pkg::PTR_TOS && wr_lo)
        tos[7:0] <= wr_data;
      else if (wr_ptr == tsc_pkg::PTR_TOS)
        tos[15:8] <= wr_data;
    end
  end

  // ==========================================================
  // Conversion sequencer
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seq_state <= tsc_pkg::SEQ_RUN;
      busy <= 1'b0;
      conv_start_o <= 1'b0;
      shut_ev <= 1'b0;
    end
    else if (ce_i)
    begin
      conv_start_o <= 1'b0;
      shut_ev <= 1'b0;
      case (seq_state)
        tsc_pkg::SEQ_RUN:
        begin
          if (conv_done_i && busy)
          begin
            busy <= 1'b0;
            if (cfg[tsc_pkg::CFG_SHUT])
            begin
              seq_state <= tsc_pkg::SEQ_SHUT;
              shut_ev <= 1'b1;
            end
          end
          else if (!busy && !cfg[tsc_pkg::CFG_SHUT])
          begin
            conv_start_o <= 1'b1;
            busy <= 1'b1;
          end
          else if (!busy)
          begin
            seq_state <= tsc_pkg::SEQ_SHUT;
            shut_ev <= 1'b1;
          end
        end
        tsc_pkg::SEQ_SHUT:
        begin
          if (one_req && wr_data[tsc_pkg::CFG_SHUT])
          begin
            conv_start_o <= 1'b1;
            busy <= 1'b1;
            seq_state <= tsc_pkg::SEQ_ONE;
          end
          else if (!cfg[tsc_pkg::CFG_SHUT])
            seq_state <= tsc_pkg::SEQ_RUN;
        end
        tsc_pkg::SEQ_ONE:
        begin
          if (conv_done_i)
          begin
            busy <= 1'b0;
            if (cfg[tsc_pkg::CFG_SHUT])
              seq_state <= tsc_pkg::SEQ_SHUT;
            else
              seq_state <= tsc_pkg::SEQ_RUN;
          end
        end
        default:
        begin
          seq_state <= tsc_pkg::SEQ_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Temperature capture
  // The format bit is looked at only when a result lands, so a change
  // takes effect with the next finished conversion.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      temp <= tsc_pkg::TEMP_RESET;
      sample_ev <= 1'b0;
    end
    else if (ce_i)
    begin
      sample_ev <= conv_done_i && busy;
      if (conv_done_i && busy)
      begin
        if (cfg[tsc_pkg::CFG_FMT])
          temp <= conv_temp_i - tsc_pkg::EXT_OFFSET;
        else
          temp <= conv_temp_i;
      end
    end
  end

  // ==========================================================
  // Alarm qualifier and output pin
  assign al_if.ce = ce_i;
  assign al_if.sample_ev = sample_ev;
  assign al_if.temp = temp;
  assign al_if.tos = tos;
  assign al_if.hyst = hyst;
  assign al_if.int_mode = cfg[tsc_pkg::CFG_MODE];
  assign al_if.fault_code = cfg[tsc_pkg::CFG_FQ_HI:tsc_pkg::CFG_FQ_LO];
  assign al_if.read_ev = rd_ev;
  assign al_if.shut_ev = shut_ev;

  tsc_alarm u_alarm
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .al(al_if.alarm)
  );

  assign alarm_level = al_if.active ? cfg[tsc_pkg::CFG_POL]
                                    : !cfg[tsc_pkg::CFG_POL];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      overtemp_alarm_oe_n_o <= tsc_pkg::ALARM_OE_RESET;
    else if (ce_i)
      overtemp_alarm_oe_n_o <= alarm_level;
  end

  assign overtemp_alarm_o = 1'b0;

endmodule

/* tsc_checker.sv */
// Concurrent checks on the pins of the sensor control top.
// Assumes a bind to tsc_top with ce_i held high.
`timescale 1ns/1ps
module tsc_checker
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_temp_i,
  input wire logic overtemp_alarm_o,
  input wire logic overtemp_alarm_oe_n_o
);
  // ==================================
  // Helper state
  logic [1:0] scl_s;
  logic [3:0] since;
  logic [7:0] low_cnt;
  logic pend;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      scl_s <= 2'h3;
    else
      scl_s <= {scl_s[0], scl_i};
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      since <= 4'hF;
    else if (scl_s == 2'h2)
      since <= 4'h0;
    else if (since != 4'hF)
      since <= since + 4'h1;
  // A long low on the data line may end in a timeout release.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      low_cnt <= 8'h00;
    else if (sda_i)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF)
      low_cnt <= low_cnt + 8'h01;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      pend <= 1'b0;
    else if (conv_start_o)
      pend <= 1'b1;
    else if (conv_done_i && ce_i)
      pend <= 1'b0;
  // ==================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pulse_one_a:
  assert property (conv_start_o && ce_i |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
  single_conv_a:
  assert property (conv_start_o |-> !pend)
    else $error("conversion started while one is outstanding");
  ack_edge_a:
  assert property ($changed(sda_oe_n_o) |-> since < 4'h9 || low_cnt > 8'h64)
    else $error("data drive changed away from a clock fall");
  ack_hold_a:
  assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*3])
    else $error("data drive shorter than a bit");
  boot_os_a:
  assert property ($fell(rst_i) |-> overtemp_alarm_oe_n_o)
    else $error("alarm pin active after power-on");
  boot_conv_a:
  assert property ($fell(rst_i) && ce_i |=> conv_start_o)
    else $error("no conversion started after power-on");
  sda_drain_a:
  assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  os_drain_a:
  assert property (overtemp_alarm_o == 1'b0)
    else $error("alarm pin driven high");
endmodule

/* tsc_i2c_mst.sv */
// Behavioural serial bus master for the sensor: clock and data drive.
// Assumes a data wire with a pull-up, resolved by the bench.
`timescale 1ns/1ps
module tsc_i2c_mst
(
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ==================================
  // Bit timing
  // The clock stands high outside frames; 110 ns low, 50 ns high, so the
  // device has its full data delay before each rising edge.
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    sda_o = 1'b1;
    #110 scl_o = 1'b1;
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #110 scl_o = 1'b1;
    #80 sda_o = 1'b1;
    #80;
  endtask
  task automatic bitx(input logic b, output logic r);
    #30 sda_o = b;
    #80 scl_o = 1'b1;
    #48 r = sda_i;
    #2 scl_o = 1'b0;
  endtask
  task automatic tx8(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    #30 sda_o = 1'b1;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    tx8(d);
    bitx(1'b1, ack);
  endtask
  task automatic rx(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule

/* testbench.sv */
// Self-checking bench: bus master partner, conversion engine, pin checks.
// Assumes the package, interface and design modules compile first.
`timescale 1ns/1ps
module testbench;
  // ==================================
  // Signals
  localparam logic [6:0] ADDR = 7'h2A; // Arbitrary bus address.
  localparam logic [15:0] HOT = 16'h5100;
  localparam logic [15:0] MID = 16'h4C00;
  localparam logic [15:0] COLD = 16'h4000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_temp_i = 16'h0000;
  logic [15:0] cur = COLD;
  logic [15:0] v;
  logic hold = 1'b0;
  logic a, scl, sda_m, sda_o, sda_oe_n_o, conv_start_o;
  logic overtemp_alarm_o, overtemp_alarm_oe_n_o;
  wire sda_w = (sda_oe_n_o | sda_o) & sda_m;
  int err_total = 0;
  int compares = 0;
  int nstart = 0;
  int ndone = 0;
  int wt = 0;
  int lims [4] = '{1, 2, 4, 6};
  int t;
  always #12.5 clk_i = ~clk_i;
  tsc_top #(.DEV_ADDR(ADDR), .TIMEOUT_CYCLES(200)) dut_u
  (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .conv_start_o(conv_start_o),
    .conv_done_i(conv_done_i), .conv_temp_i(conv_temp_i),
    .overtemp_alarm_o(overtemp_alarm_o),
    .overtemp_alarm_oe_n_o(overtemp_alarm_oe_n_o)
  );
  tsc_i2c_mst mst_u (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  // ==================================
  // Conversion engine: random latency; hold freezes a conversion.
  always @(negedge clk_i)
  begin
    conv_done_i <= 1'b0;
    if (conv_start_o === 1'b1)
    begin
      nstart <= nstart + 1;
      wt <= 2 + $urandom % 6;
    end
    else if (wt > 0 && !hold)
    begin
      wt <= wt - 1;
      conv_done_i <= (wt == 1);
      conv_temp_i <= cur;
      if (wt == 1)
        ndone <= ndone + 1;
    end
  end
  // ==================================
  // Tasks
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pin(input logic act, input logic pol);
    chk("alarm", {15'h0000, act ~^ pol}, {15'h0000, overtemp_alarm_oe_n_o});
  endtask
  task automatic feed(input logic [15:0] tv, input int n);
    int goal;
    @(posedge clk_i);
    if (n > 0)
      cur = tv;
    goal = ndone + n;
    while (ndone < goal)
      @(negedge clk_i);
    repeat (2) @(negedge clk_i);
  endtask
  task automatic hset(input logic h);
    @(posedge clk_i);
    hold = h;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    mst_u.start();
    mst_u.tx({ADDR, 1'b0}, a);
    mst_u.tx(p, a);
    mst_u.tx(d, a);
    mst_u.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    mst_u.start();
    mst_u.tx({ADDR, 1'b0}, a);
    mst_u.tx(p, a);
    mst_u.start();
    mst_u.tx({ADDR, 1'b1}, a);
    mst_u.rx(1'b0, d[15:8]);
    mst_u.rx(1'b1, d[7:0]);
    mst_u.stop();
  endtask
  // Stops the clock low while the device acknowledges its address.
  task automatic stall();
    mst_u.start();
    mst_u.tx8({ADDR, 1'b0});
    repeat (400) @(negedge clk_i);
  endtask
  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==================================
  // Scenarios
  initial
  begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    results();
  end
  initial
  begin
    t = $urandom(32'hF28D);
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    feed(COLD, 2);
    rd(8'h01, v);
    chk("cfg", 16'h0000, v);
    rd(8'h02, v);
    chk("hyst", 16'h4B00, v);
    rd(8'h03, v);
    chk("tos", 16'h5000, v);
    wr(8'h00, 8'hFF);
    rd(8'h00, v);
    chk("temp", COLD, v);
    for (int c = 0; c < 4; c++)
    begin
      feed(COLD, 6);
      wr(8'h01, 8'(c << 3));
      feed(HOT, lims[c] - 1);
      pin(1'b0, 1'b0);
      feed(MID, 1);
      feed(HOT, lims[c] - 1);
      pin(1'b0, 1'b0);
      feed(HOT, 1);
      pin(1'b1, 1'b0);
      feed(COLD, 6);
      pin(1'b0, 1'b0);
    end
    t = 16'h0800 + $urandom % 16'h3000;
    feed(16'(t), 2);
    hset(1'b1);
    wr(8'h01, 8'h20);
    rd(8'h00, v);
    chk("fmt", 16'(t), v);
    hset(1'b0);
    feed(16'(t), 2);
    rd(8'h00, v);
    chk("ext", 16'(t - 32'h4000), v);
    wr(8'h01, 8'h00);
    feed(16'(t), 2);
    rd(8'h00, v);
    chk("norm", 16'(t), v);
    wr(8'h01, 8'h02);
    feed(HOT, 1);
    pin(1'b1, 1'b0);
    feed(COLD, 2);
    pin(1'b1, 1'b0);
    hset(1'b1);
    rd(8'h00, v);
    pin(1'b0, 1'b0);
    wr(8'h01, 8'h04);
    hset(1'b0);
    feed(COLD, 6);
    pin(1'b0, 1'b1);
    feed(HOT, 1);
    pin(1'b1, 1'b1);
    wr(8'h01, 8'h01);
    repeat (200) @(negedge clk_i);
    hset(1'b1);
    t = nstart;
    repeat (200) @(negedge clk_i);
    chk("shut", 16'(t), 16'(nstart));
    wr(8'h01, 8'h81);
    rd(8'h01, v);
    chk("busy", 16'h8181, v);
    chk("one", 16'(t + 1), 16'(nstart));
    hset(1'b0);
    repeat (200) @(negedge clk_i);
    chk("back", 16'(t + 1), 16'(nstart));
    rd(8'h01, v);
    chk("done", 16'h0101, v);
    wr(8'h01, 8'h80);
    wr(8'h01, 8'h80);
    rd(8'h01, v);
    chk("run", 16'h0000, v);
    wr(8'h01, 8'h40);
    stall();
    chk("held", 16'h0000, {15'h0000, sda_oe_n_o});
    mst_u.bitx(1'b1, a);
    mst_u.tx(8'h01, a);
    mst_u.tx(8'h00, a);
    mst_u.stop();
    stall();
    chk("free", 16'h0001, {15'h0000, sda_oe_n_o});
    mst_u.bitx(1'b1, a);
    mst_u.stop();
    rd(8'h01, v);
    chk("idle", 16'h0000, v);
    results();
  end
endmodule

bind tsc_top tsc_checker chk_u
(
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .conv_start_o(conv_start_o),
  .conv_done_i(conv_done_i), .conv_temp_i(conv_temp_i),
  .overtemp_alarm_o(overtemp_alarm_o),
  .overtemp_alarm_oe_n_o(overtemp_alarm_oe_n_o)
);
